// ==== common/lpsd_pkg.sv ====
// Purpose: shared constants for the low-power sdram command engine
// Assumes: 25 MHz core clock, two banks, 32-bit data bus
// Notes:   command codes are {row strobe, column strobe, write strobe}
package lpsd_pkg;

   // geometry
   localparam int ADDR_W = 11;
   localparam int ROW_W  = 11;
   localparam int COL_W  = 8;
   localparam int DQ_W   = 32;
   localparam int LANES  = 4;
   localparam int BANKS  = 2;

   // address bit that selects auto precharge / all-bank precharge
   localparam int AP_BIT = 10;

   // command encodings with chip select low
   localparam logic [2:0] CMD_ACT = 3'h3;
   localparam logic [2:0] CMD_RD  = 3'h5;
   localparam logic [2:0] CMD_WR  = 3'h4;
   localparam logic [2:0] CMD_BST = 3'h6;
   localparam logic [2:0] CMD_PRE = 3'h2;
   localparam logic [2:0] CMD_REF = 3'h1;

   // burst length codes on the configuration port
   localparam logic [2:0] BL_1    = 3'h0;
   localparam logic [2:0] BL_2    = 3'h1;
   localparam logic [2:0] BL_4    = 3'h2;
   localparam logic [2:0] BL_8    = 3'h3;
   localparam logic [2:0] BL_FULL = 3'h7;

   // read data follows its beat by this many clocks
   localparam int READ_LATENCY = 2;

   // self refresh pacing: one internal refresh per interval
   localparam int CLK_PERIOD_PS       = 40000;
   localparam int REFRESH_INTERVAL_PS = 31250000;
   localparam int REFRESH_CYCLES      = REFRESH_INTERVAL_PS / CLK_PERIOD_PS;

   // auto refreshes that complete initialization after deep power down
   localparam logic [1:0] INIT_REFRESHES = 2'h2;

   // reset values
   localparam logic [ROW_W-1:0] REFRESH_ROW_RST = 11'h000;

   typedef enum logic [1:0] {
      LPSD_NORMAL,
      LPSD_SELF_REFRESH,
      LPSD_DEEP_POWER_DOWN
   } lpsd_mode_t;

endpackage

// ==== logic/lpsd_device.sv ====
// Purpose: memory-side command decoder, bank tracker, burst engine and array
// Assumes: all pin inputs are resynchronised by two flops before decoding
// Notes:   mode register is out of scope; burst length comes from cfg_burst_len
`timescale 1ns/1ps

// Function
// - NOP registers nothing, work continues
// - activate opens addressed row in bank
// - read/write bursts from low eight address bits
// - auto-precharge bit closes row after burst
// - read byte mask gates data two clocks later
// - write byte mask gates same-cycle data
// - precharge closes one bank or all
// - no auto precharge on full-page bursts
// - burst terminate cuts latest burst short
// - auto refresh uses internal row counter
// - self refresh entered with clock gate low
// - deep power down reads back zero until two refreshes
// - commands decoded from four strobe lines
// - byte mask line n covers byte n
// - high chip select accepts no command
module lpsd_device #(
   parameter int ROW_W = lpsd_pkg::ROW_W
) (
   // clock and reset
   input  wire logic                       clk,
   input  wire logic                       resetn,
   // command pins
   input  wire logic                       cs_n,
   input  wire logic                       ras_n,
   input  wire logic                       cas_n,
   input  wire logic                       we_n,
   input  wire logic                       clock_gate_input,
   input  wire logic                       bank_select,
   input  wire logic [lpsd_pkg::ADDR_W-1:0] addr,
   input  wire logic [lpsd_pkg::LANES-1:0]  byte_mask,
   // data pins, split into input, output and per-lane enable
   input  wire logic [lpsd_pkg::DQ_W-1:0]   dq_in,
   output logic      [lpsd_pkg::DQ_W-1:0]   dq_out_q,
   output logic      [lpsd_pkg::LANES-1:0]  dq_oe_q,
   // configuration
   input  wire logic [2:0]                  cfg_burst_len,
   // status
   output logic      [lpsd_pkg::BANKS-1:0]  bank_open_q,
   output logic                             burst_active_q,
   output logic                             self_refresh_q,
   output logic                             deep_power_down_q,
   output logic                             data_lost_q,
   output logic      [ROW_W-1:0]            refresh_row_q
);

   localparam int COL_W = lpsd_pkg::COL_W;
   localparam int DQ_W  = lpsd_pkg::DQ_W;
   localparam int LANES = lpsd_pkg::LANES;
   localparam int MEM_W = 1 + ROW_W + COL_W;
   localparam int SYN_W = 6 + lpsd_pkg::ADDR_W + LANES + DQ_W;
   localparam int SR_W  = $clog2(lpsd_pkg::REFRESH_CYCLES);
   localparam logic [SR_W-1:0] SR_LAST = SR_W'(lpsd_pkg::REFRESH_CYCLES - 1);

   if (ROW_W < 1 || ROW_W > lpsd_pkg::ADDR_W) begin : g_bad_row_w
      $error("ROW_W must lie between 1 and the address width");
   end

   // beats in a burst for a length code; reserved codes act as single beats
   function automatic logic [8:0] burst_beats(input logic [2:0] code);
      logic [8:0] n;
      n = 9'h001;
      case (code)
         lpsd_pkg::BL_2:    n = 9'h002;
         lpsd_pkg::BL_4:    n = 9'h004;
         lpsd_pkg::BL_8:    n = 9'h008;
         lpsd_pkg::BL_FULL: n = 9'h100;
         default:           n = 9'h001;
      endcase
      return n;
   endfunction

   // next column, wrapping inside the aligned burst block
   function automatic logic [COL_W-1:0] next_col(input logic [COL_W-1:0] c,
                                                 input logic [2:0]       code);
      logic [COL_W-1:0] n;
      n = c;
      case (code)
         lpsd_pkg::BL_2:    n = {c[7:1], ~c[0]};
         lpsd_pkg::BL_4:    n = {c[7:2], 2'(c[1:0] + 2'h1)};
         lpsd_pkg::BL_8:    n = {c[7:3], 3'(c[2:0] + 3'h1)};
         lpsd_pkg::BL_FULL: n = 8'(c + 8'h01);
         default:           n = c;
      endcase
      return n;
   endfunction

   // two-flop resynchroniser for every pin input
   logic [SYN_W-1:0] syn1_q;
   logic [SYN_W-1:0] syn2_q;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         syn1_q <= '0;
         syn2_q <= '0;
      end else begin
         syn1_q <= {cs_n, ras_n, cas_n, we_n, clock_gate_input, bank_select,
                    addr, byte_mask, dq_in};
         syn2_q <= syn1_q;
      end
   end

   // synchronised pin fields
   wire                     cs_n_s  = syn2_q[SYN_W-1];
   wire [2:0]               cmd_s   = syn2_q[SYN_W-2 -: 3];
   wire                     cke_s   = syn2_q[SYN_W-5];
   wire                     bank_s  = syn2_q[SYN_W-6];
   wire [lpsd_pkg::ADDR_W-1:0] addr_s = syn2_q[LANES+DQ_W +: lpsd_pkg::ADDR_W];
   wire [LANES-1:0]         mask_s  = syn2_q[DQ_W +: LANES];
   wire [DQ_W-1:0]          data_s  = syn2_q[DQ_W-1:0];

   // state registers
   lpsd_pkg::lpsd_mode_t mode_q;
   lpsd_pkg::lpsd_mode_t mode_d;
   logic [ROW_W-1:0]     row_q [lpsd_pkg::BANKS];
   logic [1:0]           open_d;
   logic                 bst_wr_q;
   logic                 bst_bank_q;
   logic                 bst_ap_q;
   logic [2:0]           bst_code_q;
   logic [COL_W-1:0]     bst_col_q;
   logic [8:0]           bst_left_q;
   logic [SR_W-1:0]      sr_cnt_q;
   logic [1:0]           init_cnt_q;

   // command decode; chip select high takes nothing, clock gate low takes only self refresh or deep power down entry
   wire in_normal  = (mode_q == lpsd_pkg::LPSD_NORMAL);
   wire cmd_sel    = in_normal && !cs_n_s && cke_s;
   wire do_act     = cmd_sel && (cmd_s == lpsd_pkg::CMD_ACT);
   wire do_pre     = cmd_sel && (cmd_s == lpsd_pkg::CMD_PRE);
   wire do_bst     = cmd_sel && (cmd_s == lpsd_pkg::CMD_BST);
   wire do_ref     = cmd_sel && (cmd_s == lpsd_pkg::CMD_REF);
   wire rw_raw     = cmd_sel && (cmd_s == lpsd_pkg::CMD_RD || cmd_s == lpsd_pkg::CMD_WR);
   wire do_rw      = rw_raw && bank_open_q[bank_s];          // idle bank is not accessed
   wire sr_entry   = in_normal && !cs_n_s && !cke_s && (cmd_s == lpsd_pkg::CMD_REF);
   wire dpd_entry  = in_normal && !cs_n_s && !cke_s && (cmd_s == lpsd_pkg::CMD_BST);
   wire leave_low  = !in_normal && cke_s;

   // current burst beat: a new read/write replaces any burst under way
   wire             beat       = do_rw || (burst_active_q && !do_bst && in_normal);
   wire             beat_wr    = do_rw ? (cmd_s == lpsd_pkg::CMD_WR) : bst_wr_q;
   wire             beat_bank  = do_rw ? bank_s : bst_bank_q;
   wire [2:0]       beat_code  = do_rw ? cfg_burst_len : bst_code_q;
   wire [COL_W-1:0] beat_col   = do_rw ? addr_s[COL_W-1:0] : bst_col_q;
   wire [8:0]       beat_left  = do_rw ? 9'(burst_beats(cfg_burst_len) - 9'h001)
                                       : bst_left_q;
   wire             beat_full  = (beat_code == lpsd_pkg::BL_FULL);
   wire             beat_ap    = do_rw ? (addr_s[lpsd_pkg::AP_BIT] && !beat_full)
                                       : bst_ap_q;
   wire             last_beat  = beat && !beat_full && (beat_left == 9'h000);
   wire             ap_close   = last_beat && beat_ap;
   wire [MEM_W-1:0] beat_idx   = {beat_bank, row_q[beat_bank], beat_col};

   // next bank open flags: activate opens, precharges close
   always_comb begin
      open_d = bank_open_q;
      if (ap_close) begin
         open_d[beat_bank] = 1'b0;
      end
      if (do_pre && addr_s[lpsd_pkg::AP_BIT]) begin
         open_d = 2'h0;
      end else if (do_pre) begin
         open_d[bank_s] = 1'b0;
      end
      if (do_act) begin
         open_d[bank_s] = 1'b1;
      end
      if (dpd_entry) begin
         open_d = 2'h0;
      end
   end

   // operating mode: self refresh and deep power down end on clock gate high
   always_comb begin
      mode_d = mode_q;
      if (sr_entry) begin
         mode_d = lpsd_pkg::LPSD_SELF_REFRESH;
      end else if (dpd_entry) begin
         mode_d = lpsd_pkg::LPSD_DEEP_POWER_DOWN;
      end else if (leave_low) begin
         mode_d = lpsd_pkg::LPSD_NORMAL;
      end
   end

   // mode and status flags
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         mode_q            <= lpsd_pkg::LPSD_NORMAL;
         self_refresh_q    <= 1'b0;
         deep_power_down_q <= 1'b0;
         bank_open_q       <= 2'h0;
      end else begin
         mode_q            <= mode_d;
         self_refresh_q    <= (mode_d == lpsd_pkg::LPSD_SELF_REFRESH);
         deep_power_down_q <= (mode_d == lpsd_pkg::LPSD_DEEP_POWER_DOWN);
         bank_open_q       <= open_d;
      end
   end

   // open row per bank, held until the next activate of that bank
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         row_q[0] <= '0;
         row_q[1] <= '0;
      end else if (do_act) begin
         row_q[bank_s] <= addr_s[ROW_W-1:0];
      end
   end

   // burst bookkeeping; NOP and deselect leave it running
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         burst_active_q <= 1'b0;
         bst_wr_q       <= 1'b0;
         bst_bank_q     <= 1'b0;
         bst_ap_q       <= 1'b0;
         bst_code_q     <= lpsd_pkg::BL_1;
         bst_col_q      <= '0;
         bst_left_q     <= 9'h000;
      end else begin
         burst_active_q <= beat && !last_beat;
         bst_wr_q       <= beat_wr;
         bst_bank_q     <= beat_bank;
         bst_ap_q       <= beat_ap;
         bst_code_q     <= beat_code;
         bst_col_q      <= next_col(beat_col, beat_code);
         bst_left_q     <= beat ? 9'(beat_left - 9'h001) : bst_left_q;
      end
   end

   // storage array; mask low writes the lane, mask high leaves it untouched
   logic [DQ_W-1:0] mem [2**MEM_W];

   always_ff @(posedge clk) begin
      for (int l = 0; l < LANES; l++) begin
         if (beat && beat_wr && !mask_s[l]) begin
            mem[beat_idx][8*l +: 8] <= data_s[8*l +: 8];
         end
      end
   end

   // read pipeline: data and mask of a beat appear two clocks later
   logic            rd_v_q;
   logic [LANES-1:0] rd_m_q;
   logic [DQ_W-1:0] rd_d_q;
   wire  [DQ_W-1:0] rd_word = data_lost_q ? '0 : mem[beat_idx];

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rd_v_q   <= 1'b0;
         rd_m_q   <= '0;
         rd_d_q   <= '0;
         dq_out_q <= '0;
         dq_oe_q  <= '0;
      end else begin
         rd_v_q   <= beat && !beat_wr;
         rd_m_q   <= mask_s;
         rd_d_q   <= rd_word;
         dq_out_q <= rd_d_q;
         dq_oe_q  <= rd_v_q ? ~rd_m_q : '0;
      end
   end

   // refresh row counter shared by auto and self refresh
   wire sr_tick = self_refresh_q && (sr_cnt_q == SR_LAST);

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         refresh_row_q <= lpsd_pkg::REFRESH_ROW_RST[ROW_W-1:0];
         sr_cnt_q      <= '0;
      end else begin
         if (do_ref || sr_tick) begin
            refresh_row_q <= ROW_W'(refresh_row_q + 1'b1);
         end
         sr_cnt_q <= (self_refresh_q && !sr_tick) ? SR_W'(sr_cnt_q + 1'b1) : '0;
      end
   end

   // array contents are void after deep power down until initialized again
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         data_lost_q <= 1'b0;
         init_cnt_q  <= 2'h0;
      end else if (dpd_entry) begin
         data_lost_q <= 1'b1;
         init_cnt_q  <= 2'h0;
      end else if (data_lost_q && do_ref) begin
         init_cnt_q  <= 2'(init_cnt_q + 2'h1);
         data_lost_q <= (2'(init_cnt_q + 2'h1) != lpsd_pkg::INIT_REFRESHES);
      end
   end

endmodule

// ==== test/lp_sdram_command_protocol_test.sv ====
// Purpose: self-checking bench for the sdram command engine
// Assumes: controller model drives the pins on the falling edge
// Notes:   bursts are four beats unless a test sets another length
`timescale 1ns/1ps
module lp_sdram_command_protocol_test;
   logic        clk, resetn, cs_n, ras_n, cas_n, we_n, cke, bank_select;
   logic        burst_active_q, self_refresh_q, deep_power_down_q, data_lost_q;
   logic [10:0] addr, refresh_row_q;
   logic [3:0]  byte_mask, dq_oe_q;
   logic [31:0] dq_in, dq_out_q;
   logic [2:0]  cfg_burst_len;
   logic [1:0]  bank_open_q;
   int          n_fail = 0;
   int          n_checks = 0;
   logic [31:0] wd [4] = '{32'h0123_4567, 32'h89ab_cdef, 32'h2468_ace0, 32'h1357_9bdf};
   logic [31:0] ones [4] = '{4{32'hffff_ffff}};
   logic [3:0]  none [4] = '{4{4'h0}};
   logic [3:0]  wm [4] = '{4'h1, 4'h2, 4'h4, 4'h8};
   logic [3:0]  rm [4] = '{4'h0, 4'h3, 4'h0, 4'hc};
   lpsd_device #(.ROW_W(11)) dut (
      .clk(clk), .resetn(resetn), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
      .clock_gate_input(cke), .bank_select(bank_select), .addr(addr),
      .byte_mask(byte_mask), .dq_in(dq_in), .dq_out_q(dq_out_q), .dq_oe_q(dq_oe_q),
      .cfg_burst_len(cfg_burst_len), .bank_open_q(bank_open_q),
      .burst_active_q(burst_active_q), .self_refresh_q(self_refresh_q),
      .deep_power_down_q(deep_power_down_q), .data_lost_q(data_lost_q),
      .refresh_row_q(refresh_row_q));
   lpsd_ctrl_model ctrl (
      .clk(clk), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
      .clock_gate_input(cke), .bank_select(bank_select), .addr(addr),
      .byte_mask(byte_mask), .dq_in(dq_in), .dq_out_q(dq_out_q), .dq_oe_q(dq_oe_q));
   // clock, 40 ns period
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // byte mask expanded to data bits
   function automatic logic [31:0] lanes(input logic [3:0] m);
      return {{8{m[3]}}, {8{m[2]}}, {8{m[1]}}, {8{m[0]}}};
   endfunction
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic final_report;
      if (n_fail == 0 && n_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // one command, then long enough for its effect to show
   task automatic op(input logic [2:0] c, input logic b, input logic [10:0] a);
      ctrl.cmd(1'b0, c, b, a, 4'h0, 32'h0);
      ctrl.idle(4);
   endtask
   // command on one bank with four cycles of mask and data
   task automatic burst(input logic [2:0] c, input logic b, input logic [10:0] a,
                        input logic [3:0] m [4], input logic [31:0] d [4]);
      ctrl.cmd(1'b0, c, b, a, m[0], d[0]);
      for (int i = 1; i < 4; i++) ctrl.cmd(1'b0, 3'h7, b, a, m[i], d[i]);
   endtask
   // main sequence
   initial begin
      resetn = 1'b0;
      cfg_burst_len = lpsd_pkg::BL_4;
      repeat (3) @(negedge clk);
      resetn = 1'b1;
      chk("bank_open", bank_open_q, 32'h0);
      ctrl.cmd(1'b1, lpsd_pkg::CMD_ACT, 1'b0, 11'h005, 4'h0, 32'h0);
      ctrl.idle(4);
      chk("bank_open", bank_open_q, 32'h0);
      op(lpsd_pkg::CMD_ACT, 1'b0, 11'h005);
      chk("bank_open", bank_open_q, 32'h1);
      op(lpsd_pkg::CMD_ACT, 1'b1, 11'h7ff);
      chk("bank_open", bank_open_q, 32'h3);
      // full write, masked rewrite, masked read with auto precharge
      burst(lpsd_pkg::CMD_WR, 1'b0, 11'h008, none, wd);
      burst(lpsd_pkg::CMD_WR, 1'b0, 11'h008, wm, ones);
      burst(lpsd_pkg::CMD_RD, 1'b0, 11'h408, rm, wd);
      // beat 0 drives in the cycle right after the burst task returns
      for (int i = 0; i < 4; i++) begin
         ctrl.idle(1);
         chk("read_oe", dq_oe_q ^ rm[i], 32'hf);
         chk("read_data", dq_out_q & ~lanes(rm[i]),
             (wd[i] | ~lanes(wm[i])) & ~lanes(rm[i]));
      end
      ctrl.idle(1);
      chk("bank_open", bank_open_q, 32'h2);
      // two-beat bursts on the other bank wrap inside their pair
      cfg_burst_len = lpsd_pkg::BL_2;
      burst(lpsd_pkg::CMD_WR, 1'b1, 11'h010, none, wd);
      burst(lpsd_pkg::CMD_RD, 1'b1, 11'h011, none, ones);
      for (int i = 0; i < 3; i++) begin
         ctrl.idle(1);
         chk("pair_oe", dq_oe_q, (i < 2) ? 32'hf : 32'h0);
         if (i < 2) chk("pair_data", dq_out_q, wd[1 - i]);
      end
      cfg_burst_len = lpsd_pkg::BL_4;
      // full page read runs until terminated and leaves the row open
      cfg_burst_len = lpsd_pkg::BL_FULL;
      op(lpsd_pkg::CMD_ACT, 1'b0, 11'h005);
      op(lpsd_pkg::CMD_RD, 1'b0, 11'h400);
      ctrl.idle(4);
      chk("burst_active", burst_active_q, 32'h1);
      op(lpsd_pkg::CMD_BST, 1'b0, 11'h000);
      chk("burst_active", burst_active_q, 32'h0);
      chk("bank_open", bank_open_q, 32'h3);
      cfg_burst_len = lpsd_pkg::BL_4;
      op(lpsd_pkg::CMD_PRE, 1'b1, 11'h000);
      chk("bank_open", bank_open_q, 32'h1);
      op(lpsd_pkg::CMD_ACT, 1'b1, 11'h123);
      op(lpsd_pkg::CMD_PRE, 1'b0, 11'h400);
      chk("bank_open", bank_open_q, 32'h0);
      for (int i = 1; i < 3; i++) begin
         op(lpsd_pkg::CMD_REF, 1'b1, 11'h7ff);
         chk("refresh_row", refresh_row_q, i);
      end
      // self refresh ignores commands until clock enable returns
      ctrl.cke = 1'b0;
      op(lpsd_pkg::CMD_REF, 1'b0, 11'h000);
      chk("self_refresh", self_refresh_q, 32'h1);
      op(lpsd_pkg::CMD_ACT, 1'b0, 11'h005);
      chk("bank_open", bank_open_q, 32'h0);
      ctrl.idle(lpsd_pkg::REFRESH_CYCLES);
      chk("refresh_row", refresh_row_q, 32'h3);
      ctrl.cke = 1'b1;
      ctrl.idle(4);
      chk("self_refresh", self_refresh_q, 32'h0);
      op(lpsd_pkg::CMD_REF, 1'b1, 11'h000);
      chk("refresh_row", refresh_row_q, 32'h4);
      // deep power down voids data until two refreshes
      ctrl.cke = 1'b0;
      op(lpsd_pkg::CMD_BST, 1'b0, 11'h000);
      chk("deep_power_down", deep_power_down_q, 32'h1);
      chk("data_lost", data_lost_q, 32'h1);
      ctrl.cke = 1'b1;
      ctrl.idle(4);
      chk("deep_power_down", deep_power_down_q, 32'h0);
      op(lpsd_pkg::CMD_REF, 1'b0, 11'h000);
      op(lpsd_pkg::CMD_REF, 1'b0, 11'h000);
      chk("data_lost", data_lost_q, 32'h0);
      final_report;
   end
   // watchdog: the tests need about nine hundred clocks
   initial begin
      repeat (5000) @(posedge clk);
      n_fail++;
      final_report;
   end
endmodule

// ==== test/lpsd_check_assertions.sv ====
// Purpose: port-level checks of the sdram command engine
// Assumes: a command on the pins takes effect four clocks after it is sampled
// Notes:   bound to every lpsd_device instance
`timescale 1ns/1ps
module lpsd_check #(
   parameter int ROW_W = lpsd_pkg::ROW_W
) (
   // clock and reset
   input wire logic             clk,
   input wire logic             resetn,
   // command pins
   input wire logic             cs_n,
   input wire logic             ras_n,
   input wire logic             cas_n,
   input wire logic             we_n,
   input wire logic             clock_gate_input,
   input wire logic             bank_select,
   input wire logic [10:0]      addr,
   input wire logic [3:0]       byte_mask,
   // outputs
   input wire logic [3:0]       dq_oe_q,
   input wire logic [1:0]       bank_open_q,
   input wire logic             burst_active_q,
   input wire logic             self_refresh_q,
   input wire logic             deep_power_down_q,
   input wire logic             data_lost_q,
   input wire logic [ROW_W-1:0] refresh_row_q
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   // command decode as the device sees it in normal mode
   wire [2:0] code = {ras_n, cas_n, we_n};
   wire       sel  = !self_refresh_q && !deep_power_down_q && !cs_n;
   wire       run  = sel && clock_gate_input;
   wire       low  = sel && !clock_gate_input;
   act_opens_a: assert property (
      run && code == lpsd_pkg::CMD_ACT |-> ##4 bank_open_q[$past(bank_select, 4)])
      else $error("activate left the bank closed");
   pre_all_a: assert property (
      run && code == lpsd_pkg::CMD_PRE && addr[10] |-> ##4 bank_open_q == 2'h0)
      else $error("precharge all left a bank open");
   pre_one_a: assert property (
      run && code == lpsd_pkg::CMD_PRE && !addr[10] |-> ##4 !bank_open_q[$past(bank_select, 4)])
      else $error("precharge left its bank open");
   refresh_step_a: assert property (
      run && code == lpsd_pkg::CMD_REF |-> ##4 refresh_row_q == $past(refresh_row_q, 4) + 1'b1)
      else $error("refresh row did not step by one");
   stop_burst_a: assert property (
      run && code == lpsd_pkg::CMD_BST |-> ##4 !burst_active_q)
      else $error("terminate left the burst running");
   self_entry_a: assert property (
      low && code == lpsd_pkg::CMD_REF |-> ##4 self_refresh_q)
      else $error("self refresh not entered");
   deep_entry_a: assert property (
      low && code == lpsd_pkg::CMD_BST |-> ##4 deep_power_down_q && data_lost_q)
      else $error("deep power down not entered");
   deep_closed_a: assert property (
      deep_power_down_q && $past(deep_power_down_q) |-> bank_open_q == 2'h0 && !burst_active_q)
      else $error("bank open in deep power down");
   self_quiet_a: assert property (
      self_refresh_q && $past(self_refresh_q) |-> $stable(bank_open_q) && dq_oe_q == 4'h0)
      else $error("activity during self refresh");
   read_mask_a: assert property (
      (dq_oe_q & $past(byte_mask, 4)) == 4'h0)
      else $error("masked lane driven");
   cover property (run && code == lpsd_pkg::CMD_RD);
   cover property (self_refresh_q);
   cover property (data_lost_q);
endmodule
bind lpsd_device lpsd_check #(.ROW_W(ROW_W)) u_check (
   .clk(clk), .resetn(resetn), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
   .clock_gate_input(clock_gate_input), .bank_select(bank_select), .addr(addr),
   .byte_mask(byte_mask), .dq_oe_q(dq_oe_q), .bank_open_q(bank_open_q),
   .burst_active_q(burst_active_q), .self_refresh_q(self_refresh_q),
   .deep_power_down_q(deep_power_down_q), .data_lost_q(data_lost_q),
   .refresh_row_q(refresh_row_q));

// ==== test/lpsd_ctrl_model.sv ====
// Purpose: behavioural memory controller on the sdram command pins
// Assumes: command pins change only on the falling clock edge; data lanes the device drives follow it after the rising edge
// Notes:   data lanes that nobody drives toggle every idle cycle
`timescale 1ns/1ps
module lpsd_ctrl_model (
   // clock
   input  wire logic        clk,
   // command pins
   output logic             cs_n,
   output logic             ras_n,
   output logic             cas_n,
   output logic             we_n,
   output logic             clock_gate_input,
   output logic             bank_select,
   output logic [10:0]      addr,
   output logic [3:0]       byte_mask,
   // data bus
   output logic [31:0]      dq_in,
   input  wire logic [31:0] dq_out_q,
   input  wire logic [3:0]  dq_oe_q
);
   logic        cke = 1'b1;
   logic [31:0] drv = 32'h0;
   // a lane carries the device level while it drives, else ours
   always_comb
      for (int i = 0; i < 4; i++)
         dq_in[8*i +: 8] = dq_oe_q[i] ? dq_out_q[8*i +: 8] : drv[8*i +: 8];
   initial {cs_n, ras_n, cas_n, we_n, clock_gate_input} = 5'h1f;
   initial {bank_select, addr, byte_mask} = 16'h0000;
   // one command cycle; clock enable follows the held level
   task automatic cmd(input logic c, input logic [2:0] code, input logic b,
                      input logic [10:0] a, input logic [3:0] m, input logic [31:0] d);
      @(negedge clk);
      cs_n = c;
      {ras_n, cas_n, we_n} = code;
      clock_gate_input = cke;
      bank_select = b;
      addr = a;
      byte_mask = m;
      drv = d;
   endtask
   // no-operation cycles with released data lines toggling
   task automatic idle(input int n);
      repeat (n) cmd(1'b0, 3'h7, 1'b0, 11'h000, 4'h0, ~drv);
   endtask
endmodule
